//--- lbt_fifo.sv
`default_nettype none
// ****************************************
// write capture fifo
// ****************************************
module lbt_fifo
	import lbt_pkg::*;
#(
	parameter int WIDTH = 36,
	parameter int DEPTH = 16
)(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW:0] wr_ff, rd_ff, nxt_wr, nxt_rd;
	logic push, pop;

	// pointers carry one extra wrap bit for honest full and empty
	always_comb
	begin
		inReady = (wr_ff[AW] == rd_ff[AW]) || (wr_ff[AW-1:0] != rd_ff[AW-1:0]);
		outValid = wr_ff != rd_ff;
		outData = mem_ff[rd_ff[AW-1:0]];
		push = inValid && inReady;
		pop = outValid && outReady;
		nxt_wr = push ? wr_ff + 1'b1 : wr_ff;
		nxt_rd = pop ? rd_ff + 1'b1 : rd_ff;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ff <= '0;
			rd_ff <= '0;
		end
		else
		begin
			wr_ff <= nxt_wr;
			rd_ff <= nxt_rd;
		end
	end

	// storage has no reset; only pointers need a defined value
	always_ff @(posedge clk)
	begin
		if (push)
			mem_ff[wr_ff[AW-1:0]] <= inData;
	end
endmodule
`default_nettype wire

//--- lbt_master.sv
`default_nettype none
// ****************************************
// initiator model, single data phase
// ****************************************
module lbt_master
	import lbt_pkg::*;
(
	input wire logic clk,
	input wire logic trdy_n,
	input wire logic stop_n,
	input wire logic devsel_n,
	input wire logic [31:0] adBus,
	output logic frame_n,
	output logic irdy_n,
	output logic [31:0] ad,
	output logic [3:0] cbe_n,
	output logic par
);
	initial
	begin
		frame_n = 1'h1;
		irdy_n = 1'h1;
		ad = 32'h0000_0000;
		cbe_n = 4'hF;
		par = 1'h0;
	end
	// resp 0 data moved, 1 target abort, 2 nobody claimed
	task automatic xfer(input logic [3:0] c, input logic [31:0] a, input logic [3:0] be,
		input logic [31:0] wd, output logic [31:0] rd, output logic [1:0] resp);
		int n;
		resp = 2'h2;
		rd = 32'h0000_0000;
		@(posedge clk);
		frame_n <= 1'h0;
		ad <= a;
		cbe_n <= c;
		if (c == CMD_DUAL_ADDR)
		begin
			@(posedge clk);
			par <= ^{ad, cbe_n};
			ad <= 32'h0000_0000;
			cbe_n <= CMD_MEM_WRITE;
		end
		@(posedge clk);
		par <= ^{ad, cbe_n};
		frame_n <= 1'h1;
		irdy_n <= 1'h0;
		cbe_n <= be;
		ad <= c[0] ? wd : ~ad; // inverted on reads, not left at last value
		// hold all but read parity until the target answers
		for (n = 0; n < 200 && resp == 2'h2; n++)
		begin
			@(posedge clk);
			par <= c[0] ? ^{ad, cbe_n} : ~par;
			if (!trdy_n)
			begin
				resp = 2'h0;
				rd = adBus;
			end
			else if (!stop_n)
				resp = 2'h1;
			else if (n > 8 && devsel_n)
				n = 200;
		end
		irdy_n <= 1'h1;
		ad <= ~ad;
		@(posedge clk);
		par <= ~par;
		repeat (4) @(posedge clk);
	endtask
endmodule
`default_nettype wire

//--- lbt_pkg.sv
// Overview of operation
// (RULE1) sample AD and parity only when qualified; control pins every edge
// (RULE2) command taken on first frame edge; byte enables held per data phase
// (RULE3) parity driven and checked one clock after the data it covers
// (RULE4) reset and interrupt lines are asynchronous, not clock-sampled
// (RULE5) each transaction is one address phase then one or more data phases
// (RULE6) bus is idle when frame and initiator ready are both deasserted
// (RULE7) first frame edge is the address phase; next edge starts data
// (RULE8) dual address cycle stretches the address phase to two clocks
// (RULE9) data moves only when both ready signals are asserted
// (RULE10) either side may insert waits by holding its ready deasserted
// (RULE11) data source asserts ready once data valid; only receiver delays
// (RULE12) master holds initiator ready and frame until the phase completes
// (RULE13) target holds devsel, target ready and stop until phase completes
// (RULE14) phase completes on initiator ready with target ready or stop
// (RULE15) master drops frame with ready asserted for the final transfer
// (RULE16) target compares address with its bases and asserts devsel on match
// (RULE17) registers reachable by memory window and optional I/O window alike
// (RULE18) I/O address is a full byte address; low bits name first byte
// (RULE19) first I/O byte enables must agree with the two low address bits
// (RULE20) all byte enables off accepts any low address bits
// (RULE21) disallowed I/O access sizes end with target abort
// (RULE22) legacy device claims fixed I/O addresses whenever I/O enable set
// (RULE23) writes update only bytes whose enables are asserted
`default_nettype none
package lbt_pkg;
	localparam logic [3:0] CMD_IO_READ = 4'h2;
	localparam logic [3:0] CMD_IO_WRITE = 4'h3;
	localparam logic [3:0] CMD_MEM_READ = 4'h6;
	localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
	localparam logic [3:0] CMD_DUAL_ADDR = 4'hD;
	localparam logic [3:0] CMD_MEM_RD_MULT = 4'hC;
	localparam logic [3:0] CMD_MEM_RD_LINE = 4'hE;
	localparam logic [3:0] CMD_MEM_WR_INV = 4'hF;
	localparam logic [3:0] BE_NONE = 4'hF;
	localparam int REG_IDX_W = 2;
	localparam int BYTE_LSB = 2;
	typedef enum logic [2:0] {LBT_IDLE, LBT_DAC, LBT_DATA, LBT_BACKOFF, LBT_TURN} lbt_state_t;
endpackage
`default_nettype wire

//--- lbt_props.sv
`default_nettype none
// ****************************************
// target port checks
// ****************************************
module lbt_props
	import lbt_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [31:0] adIn,
	input wire logic [3:0] cbeIn_n,
	input wire logic frameIn_n,
	input wire logic irdyIn_n,
	input wire logic trdyOut_n,
	input wire logic stopOut_n,
	input wire logic devselOut_n,
	input wire logic ctlOe,
	input wire logic adOe,
	input wire logic [31:0] memBase,
	input wire logic memEnable,
	input wire logic wrValid,
	input wire logic wrReady,
	input wire logic [35:0] wrData
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// memory address phase inside our window
	sequence memHit;
		$fell(frameIn_n) && memEnable && cbeIn_n[3:1] == 3'h3 && adIn[31:4] == memBase[31:4];
	endsequence
	// quiet bus, long enough to outlast the pin sync
	sequence idle6;
		(frameIn_n && irdyIn_n)[*6];
	endsequence
	chk_mem_claim: assert property (memHit |-> ##[1:5] !devselOut_n)
		else $error("memory hit not claimed");
	chk_idle_quiet: assert property (idle6 |-> devselOut_n && trdyOut_n && stopOut_n)
		else $error("target active on idle bus");
	chk_dac_skip: assert property ($fell(frameIn_n) && cbeIn_n == CMD_DUAL_ADDR |-> devselOut_n[*6])
		else $error("dual address cycle claimed");
	chk_abort_shape: assert property (!stopOut_n |-> devselOut_n && trdyOut_n)
		else $error("stop without abort shape");
	chk_claim_drive: assert property (!devselOut_n |-> ctlOe)
		else $error("claim not driven");
	chk_target_hold: assert property (!trdyOut_n && $past(!trdyOut_n) |-> $stable(devselOut_n) && stopOut_n)
		else $error("target changed mid phase");
	chk_trdy_release: assert property ($rose(trdyOut_n) |-> $past(!irdyIn_n, 2) || $past(!irdyIn_n, 3) || $past(!irdyIn_n, 4))
		else $error("ready dropped before completion");
	chk_read_drive: assert property (adOe |-> !devselOut_n || $past(!devselOut_n))
		else $error("data driven while unclaimed");
	chk_fifo_hold: assert property (wrValid && !wrReady && !$past(wrReady) |=> wrValid && $stable(wrData))
		else $error("write word lost while stalled");
endmodule
`default_nettype wire

//--- lbt_target.sv
`default_nettype none
// ****************************************
// bus target: decode, handshake, registers
// ****************************************
module lbt_target
	import lbt_pkg::*;
#(
	parameter logic [31:0] MEM_MASK = 32'hFFFF_FFF0,
	parameter logic [31:0] IO_MASK = 32'hFFFF_FFF0,
	parameter logic [31:0] LEGACY_BASE = 32'h0000_0300,
	parameter logic [31:0] LEGACY_MASK = 32'hFFFF_FFF0,
	parameter bit LEGACY_EN = 1'b0,
	parameter bit IO_DWORD_ONLY = 1'b0,
	parameter int FIFO_DEPTH = 16
)(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [31:0] adIn,
	output logic [31:0] adOut,
	output logic adOe,
	input wire logic [3:0] cbeIn_n,
	input wire logic parIn,
	output logic parOut,
	output logic parOe,
	input wire logic frameIn_n,
	input wire logic irdyIn_n,
	output logic trdyOut_n,
	output logic stopOut_n,
	output logic devselOut_n,
	output logic ctlOe,
	output logic perrOut_n,
	output logic perrOe,
	input wire logic [31:0] memBase,
	input wire logic [31:0] ioBase,
	input wire logic memEnable,
	input wire logic ioEnable,
	output logic wrValid,
	input wire logic wrReady,
	output logic [35:0] wrData,
	output logic [31:0] regTap
);
	// two-flop synchronisers on every pin input (RULE1); reset acts unsampled (RULE4)
	logic [31:0] adS1_ff, adS2_ff;
	logic [3:0] cbeS1_ff, cbeS2_ff;
	logic parS1_ff, parS2_ff, frS1_ff, frS2_ff, irS1_ff, irS2_ff;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			adS1_ff <= '0;
			adS2_ff <= '0;
			cbeS1_ff <= BE_NONE;
			cbeS2_ff <= BE_NONE;
			parS1_ff <= 1'b0;
			parS2_ff <= 1'b0;
			frS1_ff <= 1'b1;
			frS2_ff <= 1'b1;
			irS1_ff <= 1'b1;
			irS2_ff <= 1'b1;
		end
		else
		begin
			adS1_ff <= adIn;
			adS2_ff <= adS1_ff;
			cbeS1_ff <= cbeIn_n;
			cbeS2_ff <= cbeS1_ff;
			parS1_ff <= parIn;
			parS2_ff <= parS1_ff;
			frS1_ff <= frameIn_n;
			frS2_ff <= frS1_ff;
			irS1_ff <= irdyIn_n;
			irS2_ff <= irS1_ff;
		end
	end

	// ****************************************
	// transaction state
	// ****************************************
	lbt_state_t st_ff, nxt_st;
	logic [3:0] cmd_ff, nxt_cmd;
	logic [REG_IDX_W-1:0] idx_ff, nxt_idx;
	logic trdy_ff, nxt_trdy, stop_ff, nxt_stop, dsel_ff, nxt_dsel, oe_ff, nxt_oe;
	logic adOe_ff, nxt_adOe, first_ff, nxt_first;
	logic [1:0] addrLo_ff, nxt_addrLo;
	logic [31:0] rdData_ff, nxt_rdData;
	logic [31:0] regs_ff [2**REG_IDX_W];
	logic [31:0] nxt_reg;
	logic regWe;
	logic [3:0] beSel;
	logic parAcc_ff, nxt_parAcc, parOe_ff, nxt_parOe, parOut_ff, nxt_parOut;
	logic chkPend_ff, nxt_chkPend, perr_ff, nxt_perr, perrOe_ff, nxt_perrOe;
	logic wrValid_ff, nxt_wrValid;
	logic [35:0] wrData_ff, nxt_wrData;
	logic fifoInReady, fifoOutValid;
	logic [35:0] fifoOutData;
	logic idle, addrPhase, hitMem, hitIo, hitLegacy, isIo, isRead, beBad, sizeBad;
	logic complete, xfer;

	assign idle = frS2_ff && irS2_ff; // (RULE6)
	assign addrPhase = !frS2_ff && irS2_ff && st_ff == LBT_IDLE; // (RULE7)
	assign isIo = cbeS2_ff == CMD_IO_READ || cbeS2_ff == CMD_IO_WRITE;
	assign isRead = cbeS2_ff == CMD_IO_READ || cbeS2_ff == CMD_MEM_READ
		|| cbeS2_ff == CMD_MEM_RD_LINE || cbeS2_ff == CMD_MEM_RD_MULT;
	// base compare; both windows reach the same registers (RULE16) (RULE17)
	assign hitMem = memEnable && ((adS2_ff & MEM_MASK) == (memBase & MEM_MASK))
		&& (isRead || cbeS2_ff == CMD_MEM_WRITE || cbeS2_ff == CMD_MEM_WR_INV);
	assign hitIo = ioEnable && isIo && ((adS2_ff & IO_MASK) == (ioBase & IO_MASK)); // (RULE18)
	assign hitLegacy = LEGACY_EN && ioEnable && isIo
		&& ((adS2_ff & LEGACY_MASK) == LEGACY_BASE); // (RULE22)
	// first-phase enables against the latched low address bits (RULE19) (RULE20)
	always_comb
	begin
		unique case (addrLo_ff)
			2'b00: beBad = cbeS2_ff[0];
			2'b01: beBad = cbeS2_ff[1:0] != 2'b01;
			2'b10: beBad = cbeS2_ff[2:0] != 3'b011;
			default: beBad = cbeS2_ff != 4'b0111;
		endcase
		if (cbeS2_ff == BE_NONE)
			beBad = 1'b0;
	end
	// optional size restriction: full dword or no bytes only (RULE21)
	assign sizeBad = IO_DWORD_ONLY && cbeS2_ff != 4'h0 && cbeS2_ff != BE_NONE;
	assign complete = !irS2_ff && (trdy_ff || stop_ff); // (RULE14)
	assign xfer = !irS2_ff && trdy_ff; // (RULE9)
	assign beSel = ~cbeS2_ff;
	assign regWe = xfer && cmd_ff[0];

	// byte-lane merge for writes (RULE23)
	always_comb
	begin
		nxt_reg = regs_ff[idx_ff];
		for (int b = 0; b < 4; b++)
			if (beSel[b])
				nxt_reg[8*b +: 8] = adS2_ff[8*b +: 8];
	end

	// ****************************************
	// next-state logic
	// ****************************************
	always_comb
	begin
		nxt_st = st_ff;
		nxt_cmd = cmd_ff;
		nxt_idx = idx_ff;
		nxt_trdy = trdy_ff;
		nxt_stop = stop_ff;
		nxt_dsel = dsel_ff;
		nxt_oe = oe_ff;
		nxt_adOe = adOe_ff;
		nxt_first = first_ff;
		nxt_addrLo = addrLo_ff;
		nxt_rdData = rdData_ff;
		nxt_wrValid = wrValid_ff && !fifoInReady;
		nxt_wrData = wrData_ff;
		unique case (st_ff)
			LBT_IDLE:
			begin
				if (addrPhase)
				begin
					nxt_cmd = cbeS2_ff; // (RULE2)
					nxt_idx = adS2_ff[BYTE_LSB +: REG_IDX_W];
					nxt_addrLo = adS2_ff[1:0]; // (RULE18)
					if (cbeS2_ff == CMD_DUAL_ADDR)
						nxt_st = LBT_DAC; // (RULE8)
					else if (hitMem || hitIo || hitLegacy)
					begin
						nxt_st = LBT_DATA; // (RULE5)
						nxt_dsel = 1'b1;
						nxt_oe = 1'b1;
						nxt_first = 1'b1;
						nxt_adOe = isRead;
					end
				end
			end
			LBT_DAC:
				nxt_st = LBT_BACKOFF; // 64-bit addresses never match this target
			LBT_DATA:
			begin
				if (!(trdy_ff || stop_ff))
				begin
					// decide response once, then hold until completion (RULE13)
					if (first_ff && (cmd_ff == CMD_IO_READ || cmd_ff == CMD_IO_WRITE)
						&& (beBad || sizeBad))
					begin
						nxt_stop = 1'b1; // target abort
						nxt_dsel = 1'b0;
					end
					else if (!cmd_ff[0] || !wrValid_ff)
					begin
						// read source asserts ready when data valid (RULE11)
						nxt_trdy = 1'b1;
						nxt_rdData = regs_ff[idx_ff];
					end
					// write receiver waits while fifo is full (RULE10)
				end
				else if (complete)
				begin
					nxt_first = 1'b0;
					nxt_trdy = 1'b0;
					if (xfer)
					begin
						nxt_idx = idx_ff + 1'b1;
						if (cmd_ff[0])
						begin
							nxt_wrValid = 1'b1;
							nxt_wrData = {cbeS2_ff, adS2_ff};
						end
					end
					if (frS2_ff || stop_ff)
					begin
						// final phase seen: release the bus (RULE15)
						nxt_st = LBT_TURN;
						nxt_trdy = 1'b0;
						nxt_stop = 1'b0;
						nxt_dsel = 1'b0;
						nxt_adOe = 1'b0;
					end
				end
			end
			LBT_BACKOFF:
				if (idle)
					nxt_st = LBT_IDLE;
			LBT_TURN:
			begin
				nxt_oe = 1'b0;
				nxt_st = idle ? LBT_IDLE : LBT_BACKOFF;
			end
			default:
				nxt_st = LBT_IDLE;
		endcase
	end

	// parity: driven one clock after read data, checked one clock after (RULE3)
	always_comb
	begin
		nxt_parOut = ^{rdData_ff, cbeS2_ff};
		nxt_parOe = adOe_ff;
		nxt_parAcc = ^{adS2_ff, cbeS2_ff};
		nxt_chkPend = regWe;
		nxt_perr = chkPend_ff && (parAcc_ff != parS2_ff);
		nxt_perrOe = chkPend_ff || perrOe_ff && perr_ff;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_ff <= LBT_IDLE;
			cmd_ff <= 4'h0;
			idx_ff <= '0;
			trdy_ff <= 1'b0;
			stop_ff <= 1'b0;
			dsel_ff <= 1'b0;
			oe_ff <= 1'b0;
			adOe_ff <= 1'b0;
			first_ff <= 1'b0;
			addrLo_ff <= 2'h0;
			rdData_ff <= '0;
			wrValid_ff <= 1'b0;
			wrData_ff <= '0;
			parOut_ff <= 1'b0;
			parOe_ff <= 1'b0;
			parAcc_ff <= 1'b0;
			chkPend_ff <= 1'b0;
			perr_ff <= 1'b0;
			perrOe_ff <= 1'b0;
			for (int i = 0; i < 2**REG_IDX_W; i++)
				regs_ff[i] <= '0;
		end
		else
		begin
			st_ff <= nxt_st;
			cmd_ff <= nxt_cmd;
			idx_ff <= nxt_idx;
			trdy_ff <= nxt_trdy;
			stop_ff <= nxt_stop;
			dsel_ff <= nxt_dsel;
			oe_ff <= nxt_oe;
			adOe_ff <= nxt_adOe;
			first_ff <= nxt_first;
			addrLo_ff <= nxt_addrLo;
			rdData_ff <= nxt_rdData;
			wrValid_ff <= nxt_wrValid;
			wrData_ff <= nxt_wrData;
			parOut_ff <= nxt_parOut;
			parOe_ff <= nxt_parOe;
			parAcc_ff <= nxt_parAcc;
			chkPend_ff <= nxt_chkPend;
			perr_ff <= nxt_perr;
			perrOe_ff <= nxt_perrOe;
			if (regWe)
				regs_ff[idx_ff] <= nxt_reg; // (RULE23)
		end
	end

	// written words drain through the fifo; full fifo stalls target ready
	lbt_fifo #(.WIDTH(36), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.inValid(wrValid_ff),
		.inReady(fifoInReady),
		.inData(wrData_ff),
		.outValid(fifoOutValid),
		.outReady(wrReady),
		.outData(fifoOutData)
	);

	// registered copies so every output leaves a flip-flop
	logic wrVOut_ff;
	logic [35:0] wrDOut_ff;
	logic [31:0] tap_ff;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wrVOut_ff <= 1'b0;
			wrDOut_ff <= '0;
			tap_ff <= '0;
		end
		else
		begin
			wrVOut_ff <= fifoOutValid;
			wrDOut_ff <= fifoOutData;
			tap_ff <= regs_ff[0];
		end
	end

	assign adOut = rdData_ff;
	assign adOe = adOe_ff;
	assign parOut = parOut_ff;
	assign parOe = parOe_ff;
	assign trdyOut_n = ~trdy_ff;
	assign stopOut_n = ~stop_ff;
	assign devselOut_n = ~dsel_ff;
	assign ctlOe = oe_ff;
	assign perrOut_n = ~perr_ff;
	assign perrOe = perrOe_ff;
	assign wrValid = wrVOut_ff;
	assign wrData = wrDOut_ff;
	assign regTap = tap_ff;
endmodule
`default_nettype wire

//--- lbt_target_tb.sv
`default_nettype none
module lbt_target_tb
	import lbt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst_n, adOe, parOut, parOe, trdyOut_n, stopOut_n, devselOut_n, ctlOe;
	logic perrOut_n, perrOe, wrValid, wrReady, memEnable, ioEnable, frame_n, irdy_n, mPar;
	logic [31:0] adOut, regTap, memBase, ioBase, mAd;
	logic [3:0] mCbe_n;
	logic [35:0] wrData;
	logic [31:0] mem [4];
	logic [35:0] q [$];
	logic [3:0] cmds [5];
	wire logic [31:0] adBus = adOe ? adOut : mAd;
	wire logic parBus = parOe ? parOut : mPar;
	int seed = 3480;
	int n_errors = 0;
	int tests_run = 0;
	lbt_target lbt_target_i (.clk(clk), .rst_n(rst_n), .adIn(adBus), .adOut(adOut), .adOe(adOe),
		.cbeIn_n(mCbe_n), .parIn(parBus), .parOut(parOut), .parOe(parOe), .frameIn_n(frame_n),
		.irdyIn_n(irdy_n), .trdyOut_n(trdyOut_n), .stopOut_n(stopOut_n),
		.devselOut_n(devselOut_n), .ctlOe(ctlOe), .perrOut_n(perrOut_n), .perrOe(perrOe),
		.memBase(memBase), .ioBase(ioBase), .memEnable(memEnable), .ioEnable(ioEnable),
		.wrValid(wrValid), .wrReady(wrReady), .wrData(wrData), .regTap(regTap));
	lbt_master lbt_master_i (.clk(clk), .trdy_n(trdyOut_n), .stop_n(stopOut_n),
		.devsel_n(devselOut_n), .adBus(adBus), .frame_n(frame_n), .irdy_n(irdy_n), .ad(mAd),
		.cbe_n(mCbe_n), .par(mPar));
	always #20 clk = ~clk;
	// ****************************************
	// checking helpers
	// ****************************************
	task automatic cmpWord(input logic [35:0] got, input logic [35:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmpResp(input logic [1:0] got, input logic [1:0] exp);
		cmpWord({34'h0_0000_0000, got}, {34'h0_0000_0000, exp});
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// enabled byte lanes only
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] be);
		for (int i = 0; i < 4; i++)
			if (!be[i])
				o[8*i+:8] = d[8*i+:8];
		return o;
	endfunction
	function automatic logic [1:0] expResp(input logic [3:0] c, input logic [31:0] a,
		input logic [3:0] be);
		logic [3:0] m;
		logic io, ok;
		m = (4'h1 << a[1:0]) - 4'h1;
		ok = be == BE_NONE || (!be[a[1:0]] && (be & m) == m);
		io = ioEnable && c[3:1] == 3'h1 && a[31:4] == ioBase[31:4];
		if (io && !ok)
			return 2'h1;
		if (io || (memEnable && a[31:4] == memBase[31:4] && c inside {CMD_MEM_READ,
			CMD_MEM_WRITE, CMD_MEM_RD_MULT, CMD_MEM_RD_LINE, CMD_MEM_WR_INV}))
			return 2'h0;
		return 2'h2;
	endfunction
	// one transfer with its expectations
	task automatic op(input logic [3:0] c, input logic [31:0] a, input logic [3:0] be);
		logic [31:0] d, rd;
		logic [1:0] r, e;
		d = $random(seed);
		e = expResp(c, a, be);
		lbt_master_i.xfer(c, a, be, d, rd, r);
		cmpResp(r, e);
		if (e == 2'h0 && c[0])
		begin
			mem[a[3:2]] = merge(mem[a[3:2]], d, be);
			q.push_back({be, d});
		end
		if (e == 2'h0 && !c[0])
			cmpWord({4'h0, rd}, {4'h0, mem[a[3:2]]});
		cmpWord({4'h0, regTap}, {4'h0, mem[0]});
	endtask
	// slow sink: one pop every few cycles, each word checked in order
	task automatic drain;
		while (q.size() > 0)
		begin
			for (int w = 0; w < 50 && wrValid !== 1'h1; w++)
				@(posedge clk);
			cmpWord(wrData, q.pop_front());
			wrReady <= 1'h1;
			@(posedge clk);
			wrReady <= 1'h0;
			repeat (3) @(posedge clk);
		end
	endtask
	initial
	begin
		repeat (20000) @(posedge clk);
		n_errors++;
		results;
	end
	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		clk = 1'h0;
		rst_n = 1'h0;
		wrReady = 1'h0;
		memEnable = 1'h1;
		ioEnable = 1'h1;
		memBase = 32'h8000_0000;
		ioBase = 32'h0000_1000;
		cmds = '{CMD_MEM_WRITE, CMD_MEM_READ, CMD_MEM_WR_INV, CMD_MEM_RD_MULT, CMD_MEM_RD_LINE};
		for (int i = 0; i < 4; i++)
			mem[i] = 32'h0000_0000;
		repeat (2) @(posedge clk);
		rst_n <= 1'h1;
		repeat (3) @(posedge clk);
		for (int i = 0; i < 10; i++)
			op(cmds[i%5], memBase + 32'(4*(i%4)), 4'($random(seed)));
		drain;
		$display("memory commands done");
		for (int i = 0; i < 12; i++)
			op(i%2 ? CMD_IO_WRITE : CMD_IO_READ, ioBase + 32'($random(seed) & 15), 4'($random(seed)));
		op(CMD_IO_WRITE, ioBase + 32'h0000_0003, BE_NONE);
		op(CMD_IO_WRITE, ioBase + 32'h0000_0002, 4'h3);
		op(CMD_IO_READ, ioBase + 32'h0000_0001, 4'hE);
		drain;
		$display("io decode done");
		op(CMD_MEM_WRITE, memBase + 32'h0000_0100, 4'h0);
		op(CMD_DUAL_ADDR, memBase, 4'h0);
		memEnable <= 1'h0;
		@(posedge clk);
		op(CMD_MEM_WRITE, memBase, 4'h0);
		memEnable <= 1'h1;
		@(posedge clk);
		drain;
		$display("claim cases done");
		// sixteen fill the fifo, one more waits in the push stage
		while (q.size() < 17)
			op(CMD_MEM_WRITE, memBase + 32'(4*(q.size()%4)), 4'h0);
		fork
			op(CMD_MEM_WRITE, memBase, 4'h5);
		join_none
		repeat (20) @(posedge clk);
		cmpWord({34'h0_0000_0000, trdyOut_n, devselOut_n}, 36'h0_0000_0002);
		drain;
		wait fork;
		drain;
		$display("buffer fill done");
		results;
	end
endmodule
bind lbt_target lbt_props lbt_props_i (.clk(clk), .rst_n(rst_n), .adIn(adIn), .cbeIn_n(cbeIn_n),
	.frameIn_n(frameIn_n), .irdyIn_n(irdyIn_n), .trdyOut_n(trdyOut_n), .stopOut_n(stopOut_n),
	.devselOut_n(devselOut_n), .ctlOe(ctlOe), .adOe(adOe), .memBase(memBase),
	.memEnable(memEnable), .wrValid(wrValid), .wrReady(wrReady), .wrData(wrData));
`default_nettype wire
